// ---- rtl/pic_regs.svh ----
// Offsets, field positions, reset values and codes of the power and memory control registers.
`ifndef PIC_REGS_SVH
`define PIC_REGS_SVH

`define PIC_ADDR_POWER      4'hc
`define PIC_ADDR_RAM_PORT   4'hd

`define PIC_SEL_MSB         11
`define PIC_SEL_LSB         8
`define PIC_FUNC_MSB        11
`define PIC_FUNC_LSB        10
`define PIC_STATE_BIT       0

`define PIC_SEL_AUX_ONE     4'h1
`define PIC_SEL_AUX_TWO     4'h2
`define PIC_SEL_AUX_THREE   4'h3
`define PIC_SEL_VOICE_TX    4'h4
`define PIC_SEL_VOICE_RX    4'h5
`define PIC_SEL_REFERENCE   4'h6
`define PIC_SEL_BB_RX       4'h8
`define PIC_SEL_BB_TX       4'h9
`define PIC_SEL_DEVICE      4'hf

`define PIC_RST_AUX_ONE     1'h0
`define PIC_RST_AUX_TWO     1'h1
`define PIC_RST_AUX_THREE   1'h0
`define PIC_RST_VOICE_TX    1'h0
`define PIC_RST_VOICE_RX    1'h0
`define PIC_RST_REFERENCE   1'h1
`define PIC_RST_BB_RX       1'h0
`define PIC_RST_BB_TX       1'h0
`define PIC_RST_DEVICE      1'h1

`endif

// ---- rtl/pic_pkg.sv ----
// Types shared by the power and instruction memory control block.
package pic_pkg;

    typedef logic [3:0]  pic_addr_t;
    typedef logic [11:0] pic_word_t;

    typedef enum logic [1:0] {
        PIC_FN_LOW_BYTE  = 2'b00,
        PIC_FN_HIGH_BYTE = 2'b01,
        PIC_FN_POINTER   = 2'b10,
        PIC_FN_PROC_IF   = 2'b11
    } pic_func_e;

endpackage

// ---- rtl/pic_ctrl.sv ----
// Section power control and indirect instruction memory port behind the control word port.
// What this block does
// - Value bit 0 sets addressed section state.
// - Bits 11:8 select the powered section.
// - Baseband flags ORed with rx/tx pins.
// - Control port works with reference down.
// - Memory port registers have no reset.
// - Memory programming only with voice off.
// - Pointer never advances by itself.
// - Memory writes with voice on are dropped.
// - Readback lags one read behind.
// - Bits 11:10 pick the port function.
// - Control address 1101 selects memory port.
// - Voice enable starts processor.
`timescale 1ns/1ps
`default_nettype none
`include "pic_regs.svh"

module pic_ctrl #(
    parameter int ADDR_W = 9,
    parameter int PIF_W  = 10
) (
    // Clock and reset
    input  wire logic              CLK_SYS,
    input  wire logic              RESET_N,
    // Control word port
    input  wire logic              CTRL_WR,
    input  wire logic              CTRL_RD,
    input  wire pic_pkg::pic_addr_t CTRL_ADDR,
    input  wire pic_pkg::pic_word_t CTRL_WDATA,
    output logic                   CTRL_RVALID,
    output pic_pkg::pic_word_t     CTRL_RDATA,
    // Baseband path pins
    input  wire logic              BASEBAND_RX_ON_PIN,
    input  wire logic              BASEBAND_TX_ON_PIN,
    // Section power enables
    output logic                   PWR_AUX_CONVERTER_ONE,
    output logic                   PWR_AUX_CONVERTER_TWO,
    output logic                   PWR_AUX_CONVERTER_THREE,
    output logic                   PWR_VOICE_TX,
    output logic                   PWR_VOICE_RX,
    output logic                   PWR_REFERENCE,
    output logic                   PWR_BB_RX,
    output logic                   PWR_BB_TX,
    output logic                   PWR_DEVICE,
    // Voice signal processor side
    output logic                   PROC_START,
    input  wire logic [ADDR_W-1:0] PROC_FETCH_ADDR,
    output logic [15:0]            PROC_INSTR,
    output logic [PIF_W-1:0]       PROC_IF_DATA
);
    import pic_pkg::*;

    logic                rst_s1_q;
    logic                rst_s2_q;
    logic                rst_n;
    logic                aux1_q;
    logic                aux2_q;
    logic                aux3_q;
    logic                vtx_q;
    logic                vrx_q;
    logic                vref_q;
    logic                bbrx_q;
    logic                bbtx_q;
    logic                dev_q;
    logic                voice_on;
    logic                voice_on_q;
    logic                wr_pwr;
    logic                wr_ram;
    logic                rd_ram;
    logic                st;
    logic [3:0]          sel;
    pic_func_e           func;
    logic [ADDR_W-1:0]   ptr_q;
    logic [7:0]          hi_q;
    logic [7:0]          lo_q;
    logic [PIF_W-1:0]    pif_q;
    logic [15:0]         mem [0:(1<<ADDR_W)-1];
    logic [15:0]         rd_word_q;

    // Reset leaves through two flip-flops so every register reset by rst_n is released on one edge.
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    assign rst_n = rst_s2_q;

    // The control port is never gated by the reference power flag.
    // Reads reuse the value field to carry the select and subaddress bits.
    assign sel    = CTRL_WDATA[`PIC_SEL_MSB:`PIC_SEL_LSB];
    assign func   = pic_func_e'(CTRL_WDATA[`PIC_FUNC_MSB:`PIC_FUNC_LSB]);
    assign st     = CTRL_WDATA[`PIC_STATE_BIT];
    assign wr_pwr = CTRL_WR && (CTRL_ADDR == `PIC_ADDR_POWER);
    assign wr_ram = CTRL_WR && (CTRL_ADDR == `PIC_ADDR_RAM_PORT);
    assign rd_ram = CTRL_RD && (CTRL_ADDR == `PIC_ADDR_RAM_PORT);
    assign voice_on = vtx_q || vrx_q;

    // The complete-device flag gates nothing here, the analog sections decide its effect.
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            aux1_q <= `PIC_RST_AUX_ONE;
            aux2_q <= `PIC_RST_AUX_TWO;
            aux3_q <= `PIC_RST_AUX_THREE;
            vtx_q  <= `PIC_RST_VOICE_TX;
            vrx_q  <= `PIC_RST_VOICE_RX;
            vref_q <= `PIC_RST_REFERENCE;
            bbrx_q <= `PIC_RST_BB_RX;
            bbtx_q <= `PIC_RST_BB_TX;
            dev_q  <= `PIC_RST_DEVICE;
        end else if (wr_pwr) begin
            case (sel)
                `PIC_SEL_AUX_ONE:   aux1_q <= st;
                `PIC_SEL_AUX_TWO:   aux2_q <= st;
                `PIC_SEL_AUX_THREE: aux3_q <= st;
                `PIC_SEL_VOICE_TX:  vtx_q  <= st;
                `PIC_SEL_VOICE_RX:  vrx_q  <= st;
                `PIC_SEL_REFERENCE: vref_q <= st;
                `PIC_SEL_BB_RX:     bbrx_q <= st;
                `PIC_SEL_BB_TX:     bbtx_q <= st;
                `PIC_SEL_DEVICE:    dev_q  <= st;
                default: ;
            endcase
        end
    end

    assign PWR_AUX_CONVERTER_ONE   = aux1_q;
    assign PWR_AUX_CONVERTER_TWO   = aux2_q;
    assign PWR_AUX_CONVERTER_THREE = aux3_q;
    assign PWR_VOICE_TX            = vtx_q;
    assign PWR_VOICE_RX            = vrx_q;
    assign PWR_REFERENCE           = vref_q;
    assign PWR_BB_RX               = bbrx_q || BASEBAND_RX_ON_PIN;
    assign PWR_BB_TX               = bbtx_q || BASEBAND_TX_ON_PIN;
    assign PWR_DEVICE              = dev_q;

    // Processor start fires once on the edge from both voice paths off to either on.
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            voice_on_q <= 1'b0;
            PROC_START <= 1'b0;
        end else begin
            voice_on_q <= voice_on;
            PROC_START <= voice_on && !voice_on_q;
        end
    end

    // Port registers deliberately carry no reset, so they hold garbage until written.
    // The interface register is held while voice runs, just like the byte registers.
    always_ff @(posedge CLK_SYS) begin
        if (wr_ram && !voice_on) begin
            case (func)
                PIC_FN_LOW_BYTE:  lo_q  <= CTRL_WDATA[7:0];
                PIC_FN_HIGH_BYTE: hi_q  <= CTRL_WDATA[7:0];
                PIC_FN_POINTER:   ptr_q <= CTRL_WDATA[ADDR_W-1:0];
                PIC_FN_PROC_IF:   pif_q <= CTRL_WDATA[PIF_W-1:0];
                default: ;
            endcase
        end
    end
    assign PROC_IF_DATA = pif_q;

    // The low byte completes the word, so the high byte must already be loaded.
    always_ff @(posedge CLK_SYS) begin
        if (wr_ram && !voice_on && func == PIC_FN_LOW_BYTE) begin
            mem[ptr_q] <= {hi_q, CTRL_WDATA[7:0]};
        end
    end

    // The fetch port reads the array every cycle, which is why programming needs voice off.
    always_ff @(posedge CLK_SYS) begin
        PROC_INSTR <= mem[PROC_FETCH_ADDR];
    end

    // Reads hand out the word fetched on the previous read, then fetch the current pointer.
    always_ff @(posedge CLK_SYS) begin
        if (rd_ram) begin
            rd_word_q <= mem[ptr_q];
        end
    end

    // Answers stand one cycle and fall back to zero, so a stale answer never looks fresh.
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            CTRL_RVALID <= 1'b0;
            CTRL_RDATA  <= 12'h000;
        end else begin
            CTRL_RVALID <= CTRL_RD;
            if (!CTRL_RD) begin
                CTRL_RDATA <= 12'h000;
            end else if (CTRL_ADDR == `PIC_ADDR_POWER) begin
                case (CTRL_WDATA[`PIC_SEL_MSB:`PIC_SEL_LSB])
                    `PIC_SEL_AUX_ONE:   CTRL_RDATA <= {CTRL_WDATA[11:8], 7'h00, aux1_q};
                    `PIC_SEL_AUX_TWO:   CTRL_RDATA <= {CTRL_WDATA[11:8], 7'h00, aux2_q};
                    `PIC_SEL_AUX_THREE: CTRL_RDATA <= {CTRL_WDATA[11:8], 7'h00, aux3_q};
                    `PIC_SEL_VOICE_TX:  CTRL_RDATA <= {CTRL_WDATA[11:8], 7'h00, vtx_q};
                    `PIC_SEL_VOICE_RX:  CTRL_RDATA <= {CTRL_WDATA[11:8], 7'h00, vrx_q};
                    `PIC_SEL_REFERENCE: CTRL_RDATA <= {CTRL_WDATA[11:8], 7'h00, vref_q};
                    `PIC_SEL_BB_RX:     CTRL_RDATA <= {CTRL_WDATA[11:8], 7'h00, bbrx_q};
                    `PIC_SEL_BB_TX:     CTRL_RDATA <= {CTRL_WDATA[11:8], 7'h00, bbtx_q};
                    `PIC_SEL_DEVICE:    CTRL_RDATA <= {CTRL_WDATA[11:8], 7'h00, dev_q};
                    default:            CTRL_RDATA <= 12'h000;
                endcase
            end else if (rd_ram) begin
                case (func)
                    PIC_FN_LOW_BYTE:  CTRL_RDATA <= {4'h0, rd_word_q[7:0]};
                    PIC_FN_HIGH_BYTE: CTRL_RDATA <= {4'h0, rd_word_q[15:8]};
                    PIC_FN_POINTER:   CTRL_RDATA <= 12'(ptr_q);
                    PIC_FN_PROC_IF:   CTRL_RDATA <= 12'(pif_q);
                    default:          CTRL_RDATA <= 12'h000;
                endcase
            end else begin
                CTRL_RDATA <= 12'h000;
            end
        end
    end

endmodule // pic_ctrl
`default_nettype wire

// ---- tb/pic_ctrl_properties.sv ----
// Port-level assertions for the power and memory control block.
`timescale 1ns/1ps
`default_nettype none
module pic_ctrl_chk (
    // Control port
    input wire logic               CLK_SYS,
    input wire logic               RESET_N,
    input wire logic               CTRL_WR,
    input wire logic               CTRL_RD,
    input wire pic_pkg::pic_addr_t CTRL_ADDR,
    input wire pic_pkg::pic_word_t CTRL_WDATA,
    input wire logic               CTRL_RVALID,
    input wire pic_pkg::pic_word_t CTRL_RDATA,
    // Pins and outputs
    input wire logic               BASEBAND_RX_ON_PIN,
    input wire logic               BASEBAND_TX_ON_PIN,
    input wire logic               PWR_AUX_CONVERTER_ONE,
    input wire logic               PWR_VOICE_TX,
    input wire logic               PWR_VOICE_RX,
    input wire logic               PWR_REFERENCE,
    input wire logic               PWR_DEVICE,
    input wire logic               PWR_BB_RX,
    input wire logic               PWR_BB_TX,
    input wire logic               PROC_START
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESET_N);
    logic pw_wr;
    assign pw_wr = CTRL_WR && CTRL_ADDR == 4'hc;
    sequence s_start;
        PROC_START ##1 !PROC_START;
    endsequence
    a_bb_rx_or: assert property (BASEBAND_RX_ON_PIN |-> PWR_BB_RX)
        else $error("rx pin ignored");
    a_bb_tx_or: assert property (BASEBAND_TX_ON_PIN |-> PWR_BB_TX)
        else $error("tx pin ignored");
    a_voice_tx_set: assert property (pw_wr && CTRL_WDATA[11:8] == 4'h4 |=>
        PWR_VOICE_TX == $past(CTRL_WDATA[0])) else $error("voice tx state wrong");
    a_device_set: assert property (pw_wr && CTRL_WDATA[11:8] == 4'hf |=>
        PWR_DEVICE == $past(CTRL_WDATA[0])) else $error("device state wrong");
    a_unknown_sel: assert property (
        pw_wr && CTRL_WDATA[11:8] inside {4'h0, 4'h7, [4'ha:4'he]}
        |=> $stable({PWR_AUX_CONVERTER_ONE, PWR_VOICE_TX, PWR_VOICE_RX, PWR_REFERENCE,
        PWR_DEVICE}))
        else $error("unlisted code changed power");
    a_start_pulse: assert property ($rose(PWR_VOICE_TX || PWR_VOICE_RX) |=> s_start)
        else $error("no start pulse");
    a_read_answer: assert property (CTRL_RD |=> CTRL_RVALID)
        else $error("read not answered");
    a_rdata_idle: assert property (!CTRL_RVALID |-> CTRL_RDATA == 12'h000)
        else $error("read data not idle");
endmodule // pic_ctrl_chk
bind pic_ctrl pic_ctrl_chk u_chk (
    .CLK_SYS               (CLK_SYS),
    .RESET_N               (RESET_N),
    .CTRL_WR               (CTRL_WR),
    .CTRL_RD               (CTRL_RD),
    .CTRL_ADDR             (CTRL_ADDR),
    .CTRL_WDATA            (CTRL_WDATA),
    .CTRL_RVALID           (CTRL_RVALID),
    .CTRL_RDATA            (CTRL_RDATA),
    .BASEBAND_RX_ON_PIN    (BASEBAND_RX_ON_PIN),
    .BASEBAND_TX_ON_PIN    (BASEBAND_TX_ON_PIN),
    .PWR_AUX_CONVERTER_ONE (PWR_AUX_CONVERTER_ONE),
    .PWR_VOICE_TX          (PWR_VOICE_TX),
    .PWR_VOICE_RX          (PWR_VOICE_RX),
    .PWR_REFERENCE         (PWR_REFERENCE),
    .PWR_DEVICE            (PWR_DEVICE),
    .PWR_BB_RX             (PWR_BB_RX),
    .PWR_BB_TX             (PWR_BB_TX),
    .PROC_START            (PROC_START)
);
`default_nettype wire

// ---- tb/pic_host.sv ----
// Host model that issues control words to the block.
`timescale 1ns/1ps
`default_nettype none
module pic_host (
    // Control port
    input  wire logic               clk,
    output logic                    wr,
    output logic                    rd,
    output pic_pkg::pic_addr_t      addr,
    output pic_pkg::pic_word_t      wdata,
    input  wire logic               rvalid,
    input  wire pic_pkg::pic_word_t rdata
);
    import pic_pkg::*;
    initial begin
        {rd, wr, addr, wdata} = '0;
    end
    // Released lines show the inverse value, so a stale word cannot pass for a fresh one.
    task automatic xfer(input logic r, input logic [15:0] aw, output logic [12:0] vq);
        @(negedge clk);
        {rd, wr, addr, wdata} = {r, !r, aw};
        @(negedge clk);
        {rd, wr, addr, wdata} = {2'b00, ~aw};
        vq = {rvalid, rdata};
    endtask
    // The pointer is reloaded for every word because it never moves by itself.
    task automatic prog(input logic [8:0] p, input logic [15:0] w);
        logic [12:0] vq;
        xfer(1'b0, {4'hd, 3'b100, p}, vq);
        xfer(1'b0, {4'hd, 4'h4, w[15:8]}, vq);
        xfer(1'b0, {4'hd, 4'h0, w[7:0]}, vq);
    endtask
endmodule // pic_host
`default_nettype wire

// ---- tb/pic_ctrl_bench.sv ----
// Self-checking bench for the power and memory control block.
`timescale 1ns/1ps
`default_nettype none
`include "pic_regs.svh"
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin n_fail++; \
    $display("mismatch %s exp %h got %h", n, e, s); end end
module pic_ctrl_bench;
    import pic_pkg::*;
    logic        clk_sys, reset_n, rx_pin, tx_pin, wr, rd, rvalid;
    pic_addr_t   addr;
    pic_word_t   wdata, rdata;
    logic [8:0]  fetch, e;
    logic [12:0] vq;
    logic [15:0] instr;
    wire  [8:0]  pw;
    wire  [9:0]  pif;
    logic [3:0]  code [9] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hf};
    int          n_fail = 0;
    int          cmp_count = 0;
    pic_host u_host (.clk(clk_sys), .wr(wr), .rd(rd), .addr(addr), .wdata(wdata),
        .rvalid(rvalid), .rdata(rdata));
    pic_ctrl u_dut (.CLK_SYS(clk_sys), .RESET_N(reset_n), .CTRL_WR(wr), .CTRL_RD(rd),
        .CTRL_ADDR(addr), .CTRL_WDATA(wdata), .CTRL_RVALID(rvalid), .CTRL_RDATA(rdata),
        .BASEBAND_RX_ON_PIN(rx_pin), .BASEBAND_TX_ON_PIN(tx_pin),
        .PWR_AUX_CONVERTER_ONE(pw[0]), .PWR_AUX_CONVERTER_TWO(pw[1]),
        .PWR_AUX_CONVERTER_THREE(pw[2]), .PWR_VOICE_TX(pw[3]), .PWR_VOICE_RX(pw[4]),
        .PWR_REFERENCE(pw[5]), .PWR_BB_RX(pw[6]), .PWR_BB_TX(pw[7]), .PWR_DEVICE(pw[8]),
        .PROC_START(), .PROC_FETCH_ADDR(fetch), .PROC_INSTR(instr), .PROC_IF_DATA(pif));
    task automatic wr_pwr(input logic [3:0] s, input logic b);
        u_host.xfer(1'b0, {4'hc, s, 7'h00, b}, vq);
    endtask
    task automatic t_reset;
        e = {`PIC_RST_DEVICE, `PIC_RST_BB_TX, `PIC_RST_BB_RX, `PIC_RST_REFERENCE,
            `PIC_RST_VOICE_RX, `PIC_RST_VOICE_TX, `PIC_RST_AUX_THREE, `PIC_RST_AUX_TWO,
            `PIC_RST_AUX_ONE};
        `CHK("reset power", e, pw)
    endtask
    // Two rounds flip every section and bring it back, aux two, the reference and device off between.
    task automatic t_codes;
        for (int k = 0; k < 18; k++) begin
            e[k % 9] = !e[k % 9];
            wr_pwr(code[k % 9], e[k % 9]);
            `CHK("power state", e, pw)
        end
        for (int k = 0; k < 16; k++) if (!(k inside {1, 2, 3, 4, 5, 6, 8, 9, 15})) begin
            wr_pwr(k[3:0], 1'b1);
            `CHK("unlisted code", e, pw)
        end
    endtask
    task automatic t_pins;
        for (int k = 0; k < 4; k++) begin
            @(negedge clk_sys);
            {tx_pin, rx_pin} = k[1:0];
            #1;
            `CHK("bb pins", k[1:0], pw[7:6])
        end
        @(negedge clk_sys);
        {tx_pin, rx_pin} = 2'b00;
        wr_pwr(4'h9, 1'b1);
        `CHK("bb flag", 2'b10, pw[7:6])
        wr_pwr(4'h9, 1'b0);
    endtask
    task automatic t_instruction_memory;
        u_host.prog(9'h005, 16'ha5c3);
        u_host.prog(9'h006, 16'h3c5a);
        u_host.xfer(1'b0, {4'hd, 4'h4, 8'h11}, vq);
        u_host.xfer(1'b0, {4'hd, 4'h0, 8'h22}, vq);
        fetch = 9'h006;
        repeat (2) @(negedge clk_sys);
        `CHK("pointer kept", 16'h1122, instr)
        wr_pwr(4'h5, 1'b1);
        u_host.prog(9'h005, 16'hffff);
        wr_pwr(4'h5, 1'b0);
        fetch = 9'h005;
        repeat (2) @(negedge clk_sys);
        `CHK("word kept", 16'ha5c3, instr)
        u_host.xfer(1'b0, {4'hd, 3'b100, 9'h005}, vq);
        u_host.xfer(1'b1, 16'hd000, vq);
        u_host.xfer(1'b0, {4'hd, 3'b100, 9'h006}, vq);
        u_host.xfer(1'b1, 16'hd000, vq);
        `CHK("lagged read", 13'h10c3, vq)
    endtask
    // Reads the high byte, pointer and interface functions and the power word, and checks the interface register gate.
    task automatic t_readback;
        u_host.xfer(1'b1, 16'hd400, vq);
        `CHK("high byte read", 13'h1011, vq)
        u_host.xfer(1'b1, 16'hd800, vq);
        `CHK("pointer read", 13'h1006, vq)
        u_host.xfer(1'b0, 16'hdf5a, vq);
        `CHK("interface reg", 10'h35a, pif)
        u_host.xfer(1'b1, 16'hdc00, vq);
        `CHK("interface read", 13'h135a, vq)
        wr_pwr(4'h4, 1'b1);
        u_host.xfer(1'b0, 16'hdc00, vq);
        wr_pwr(4'h4, 1'b0);
        `CHK("interface kept", 10'h35a, pif)
        u_host.xfer(1'b1, 16'hc600, vq);
        `CHK("power read", 13'h1601, vq)
        u_host.xfer(1'b1, 16'h0000, vq);
        `CHK("other address", 13'h1000, vq)
    endtask
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        {reset_n, rx_pin, tx_pin} = 3'b000;
        fetch = 9'h000;
        repeat (16) @(negedge clk_sys);
        reset_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        t_reset;
        t_codes;
        t_pins;
        t_instruction_memory;
        t_readback;
        tally_and_finish;
    end
    initial begin
        #100000;
        n_fail++;
        tally_and_finish;
    end
endmodule // pic_ctrl_bench
`default_nettype wire
